// ### verilog/bdc_pkg.sv
// What this block does
// - Entry copies condition code into holding register
// - Holding register write changes restored code
// - Holding and page registers accessible only unsecured
// - Page index bit 7 enables paged access
// - Debug space commands to 0x3FF00-0x3FF0F never go global
// - Page index bits 3-0 select page
// - Fixed read-only family identifier at 0x3FF0F
// - Host sends hardware and firmware commands serially
// - Hardware commands accepted anytime except secure limits; memory and register commands dropped while an access waits
// - Firmware commands only unsecured and active
// - Secure reset: erased check sets both flags
// - Failed erase check sets enable only
// - Secured: debug only in special single-chip
// - Disabled: enter command ignored, others brief delay
// - Activation sources; special reset enabled and active
// - CPU finishes current instruction before firmware
// - Breakpoint type picks before or after
// - Debug space maps 0x3FF00 to 0x3FFFF
// - Debug registers hidden from user reads
// - Overlap entry increments saved program counter
// - Status bit 7 is debug enable
// - Status bit 6 set on entry, cleared exit
// - Enter-debug opcode 90 needs firmware enabled
// - Memory access steals cycle after 128 clocks
package bdc_pkg;
  localparam logic [17:0] BDC_SPACE_BASE   = 18'h3FF00;
  localparam logic [17:0] BDC_REG_LAST     = 18'h3FF0B;
  localparam logic [17:0] BDC_STATUS_ADDR  = 18'h3FF01;
  localparam logic [17:0] BDC_HOLD_ADDR    = 18'h3FF06;
  localparam logic [17:0] BDC_PAGE_ADDR    = 18'h3FF08;
  localparam logic [17:0] BDC_FAMILY_ADDR  = 18'h3FF0F;
  localparam int          BDC_ENABLE_BIT   = 7;
  localparam int          BDC_ACTIVE_BIT   = 6;
  localparam int          BDC_UNSECURED_FLAG_BIT    = 1;
  localparam int          BDC_PAGE_EN_BIT  = 7;
  localparam logic [7:0]  BDC_HOLD_RST_SSC = 8'hC8;
  localparam logic [7:0]  BDC_HOLD_RST_OTH = 8'h00;
  localparam logic [7:0]  BDC_PAGE_RST     = 8'h00;
  localparam logic [7:0]  BDC_OP_ENTER     = 8'h90;
  localparam logic [7:0]  BDC_OP_RD_BYTE   = 8'hE0;
  localparam logic [7:0]  BDC_OP_WR_BYTE   = 8'hC0;
  localparam logic [7:0]  BDC_OP_RD_BD     = 8'hE4;
  localparam logic [7:0]  BDC_OP_WR_BD     = 8'hC4;
  localparam logic [7:0]  BDC_OP_WR_PC     = 8'h43;
  localparam int          BDC_STEAL_CYCLES = 128;
  localparam int          BDC_DELAY_NS     = 80;
  localparam int          BDC_CLK_MHZ      = 125;
  localparam int          BDC_DELAY_CYC    = (BDC_DELAY_NS * BDC_CLK_MHZ + 999) / 1000;

  typedef struct packed {
    logic        valid;
    logic [7:0]  opcode;
    logic [17:0] addr;
    logic [7:0]  data;
  } bdc_cmd_t;

  typedef struct packed {
    logic        req;
    logic        write;
    logic        debug_space;
    logic        paged;
    logic [3:0]  page;
    logic [17:0] addr;
    logic [7:0]  data;
  } bdc_mem_t;

  function automatic logic bdc_in_space(input logic [17:0] a);
    return a >= BDC_SPACE_BASE;
  endfunction
endpackage

// ### verilog/bdc_regbank.sv
`timescale 1ns/1ps
module bdc_regbank
  import bdc_pkg::*;
(
  input  wire logic       clock,    // Bus clock
  input  wire logic       rst,      // Async reset
  input  wire logic       ssc_mode, // Special single-chip mode
  input  wire logic       hold_ld,  // Load holding register
  input  wire logic [7:0] hold_d,   // Holding data
  input  wire logic       page_ld,  // Load page index
  input  wire logic [7:0] page_d,   // Page data
  input  wire logic       init,     // Mode-dependent reload
  output logic      [7:0] hold_q,   // Holding register
  output logic      [7:0] page_q    // Page index register
);
  typedef struct packed {
    logic [7:0] hold;
    logic [7:0] page;
  } bdc_rb_t;
  bdc_rb_t st, next_st;

  always_comb begin
    next_st = st;
    if (init) begin
      next_st.hold = ssc_mode ? BDC_HOLD_RST_SSC : BDC_HOLD_RST_OTH;
    end else if (hold_ld) begin
      next_st.hold = hold_d;
    end
    if (page_ld) begin
      next_st.page = {page_d[7], 3'h0, page_d[3:0]};
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign hold_q = st.hold;
  assign page_q = st.page;

  AST_INIT_LOAD: assert property (@(posedge clock) disable iff (rst)
    init && ssc_mode |=> hold_q == BDC_HOLD_RST_SSC) else $error("hold reset wrong");
endmodule

// ### verilog/bdc_steal.sv
`timescale 1ns/1ps
module bdc_steal
  import bdc_pkg::*;
#(
  parameter int LIMIT = BDC_STEAL_CYCLES
)(
  input  wire logic clock,    // Bus clock
  input  wire logic rst,      // Async reset
  input  wire logic pending,  // Access waiting
  input  wire logic bus_free, // CPU idle cycle
  output logic      go,       // Access now
  output logic      freeze    // Freeze CPU request
);
  if (LIMIT < 2 || LIMIT > 255) begin
    $error("LIMIT out of range");
  end
  typedef struct packed {
    logic [7:0] cnt;
    logic       freeze;
  } bdc_st_t;
  bdc_st_t st, next_st;

  always_comb begin
    next_st = st;
    if (!pending || bus_free || st.freeze) begin
      next_st.cnt = '0;
      next_st.freeze = 1'b0;
    end else if (st.cnt == 8'(LIMIT - 1)) begin
      next_st.freeze = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 8'h01;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign freeze = st.freeze;
  assign go = pending && (bus_free || st.freeze);

  AST_STEAL_BOUND: assert property (@(posedge clock) disable iff (rst)
    pending && !go |-> ##[1:129] go) else $error("no cycle stolen");
endmodule

// ### verilog/bdc_core.sv
`timescale 1ns/1ps
module bdc_core
  import bdc_pkg::*;
#(
  parameter logic [7:0] FAMILY_IDENTIFIER = 8'h5A, // Arbitrary neutral value
  parameter int         DELAY     = BDC_DELAY_CYC
)(
  input  wire logic        clock,         // Bus clock
  input  wire logic        rst,           // Async reset, high
  input  wire logic        ssc_mode,      // Special single-chip mode
  input  wire logic        secured,       // Device secured
  input  wire logic        erase_done,    // Erase check finished
  input  wire logic        erase_ok,      // Memories verified erased
  input  wire bdc_cmd_t    cmd,           // Decoded serial command
  input  wire logic        fw_cmd,        // Command is firmware class
  input  wire logic        halt_insn,     // CPU halt-to-debug instruction
  input  wire logic        brk_before,    // Breakpoint, enter before next
  input  wire logic        brk_after,     // Breakpoint, enter after next
  input  wire logic        insn_end,      // CPU instruction boundary
  input  wire logic [7:0]  cpu_ccr,       // User condition code
  input  wire logic [15:0] cpu_pc,        // User program counter
  input  wire logic        fw_exit,       // Firmware exit store
  input  wire logic        bus_free,      // Free bus cycle
  input  wire logic        user_rd,       // User program read
  input  wire logic [17:0] user_addr,     // User read address
  output bdc_mem_t         mem,           // Memory access request
  output logic             cpu_freeze,    // Steal a cycle
  output logic             cpu_stall,     // Brief activation delay
  output logic             fw_go,         // Firmware command run
  output logic             fw_map,        // Firmware table in map
  output logic             secure_map,    // Secure table overlay
  output logic [7:0]       restore_ccr,   // Code restored on exit
  output logic [15:0]      saved_pc,      // Saved program counter
  output logic [7:0]       rd_data,       // Debug space read data
  output logic             rd_valid,      // Read data strobe
  output logic             user_hidden,   // User read blocked
  output logic [7:0]       status         // Debug status register
);
  // The delay counter is eight bits wide and must count at least once
  if (DELAY < 1 || DELAY > 255) begin
    $error("DELAY out of range");
  end

  typedef enum {S_RESET, S_SECCHK, S_LOOP, S_RUN, S_PEND, S_ACTIVE} bdc_state_t;

  typedef struct packed {
    bdc_state_t  fsm;
    logic        enable;
    logic        active;
    logic        unsecured_flag;
    logic        brk_wait;
    logic [7:0]  dly;
    logic        stall;
    logic        fw_go;
    bdc_mem_t    mem;
    logic [15:0] pc;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        hidden;
    logic        secmap;
  } bdc_core_t;

  bdc_core_t st, next_st;
  logic [7:0] hold_q, page_q;
  logic       hold_ld, page_ld, rb_init;
  logic [7:0] hold_d;
  logic       steal_go, steal_freeze;
  logic       open_access, is_hw, is_bd, is_wr, dbg_allowed, trigger;

  bdc_regbank u_regs (
    .clock    (clock),
    .rst      (rst),
    .ssc_mode (ssc_mode),
    .hold_ld  (hold_ld),
    .hold_d   (hold_d),
    .page_ld  (page_ld),
    .page_d   (cmd.data),
    .init     (rb_init),
    .hold_q   (hold_q),
    .page_q   (page_q)
  );

  bdc_steal u_steal (
    .clock    (clock),
    .rst      (rst),
    .pending  (st.mem.req),
    .bus_free (bus_free),
    .go       (steal_go),
    .freeze   (steal_freeze)
  );

  always_comb begin
    dbg_allowed = !secured || ssc_mode;
    open_access = !secured || st.unsecured_flag;
    is_hw = cmd.valid && !fw_cmd && dbg_allowed;
    is_bd = (cmd.opcode == BDC_OP_RD_BD) || (cmd.opcode == BDC_OP_WR_BD);
    is_wr = (cmd.opcode == BDC_OP_WR_BD) || (cmd.opcode == BDC_OP_WR_BYTE);
    trigger = 1'b0;
    hold_ld = 1'b0;
    hold_d = cmd.data;
    page_ld = 1'b0;
    rb_init = 1'b0;
    next_st = st;
    next_st.rvalid = 1'b0;
    next_st.fw_go = 1'b0;
    next_st.hidden = 1'b0;

    unique case (st.fsm)
      S_RESET: begin
        rb_init = 1'b1;
        if (ssc_mode && secured) begin
          next_st.fsm = S_SECCHK;
        end else begin
          next_st.enable = ssc_mode;
          next_st.active = ssc_mode;
          next_st.fsm = ssc_mode ? S_ACTIVE : S_RUN;
        end
      end
      S_SECCHK: begin
        if (erase_done) begin
          if (erase_ok) begin
            next_st.unsecured_flag = 1'b1;
            next_st.enable = 1'b1;
            next_st.active = 1'b1;
            next_st.fsm = S_ACTIVE;
          end else begin
            next_st.enable = 1'b1;
            next_st.fsm = S_LOOP;
          end
        end
      end
      S_LOOP: begin
        next_st.fsm = S_LOOP;
      end
      S_RUN: begin
        if (st.enable && open_access) begin
          if ((is_hw && cmd.opcode == BDC_OP_ENTER) || halt_insn || brk_before) begin
            trigger = 1'b1;
          end else if (brk_after) begin
            next_st.brk_wait = 1'b1;
          end
        end else if (halt_insn || brk_before || brk_after) begin
          next_st.stall = 1'b1;
          next_st.dly = 8'(DELAY);
        end
        if (st.brk_wait && insn_end) begin
          trigger = 1'b1;
        end
        if (trigger) begin
          next_st.brk_wait = 1'b0;
          next_st.fsm = S_PEND;
        end
      end
      S_PEND: begin
        if (insn_end) begin
          hold_ld = 1'b1;
          hold_d = cpu_ccr;
          next_st.pc = bdc_in_space({2'b11, cpu_pc}) ? cpu_pc + 16'h0001 : cpu_pc;
          next_st.active = 1'b1;
          next_st.fsm = S_ACTIVE;
        end
      end
      S_ACTIVE: begin
        next_st.fw_go = cmd.valid && fw_cmd && open_access;
        if (cmd.valid && fw_cmd && cmd.opcode == BDC_OP_WR_PC && next_st.fw_go) begin
          next_st.pc = {8'h00, cmd.data};
        end
        if (fw_exit) begin
          next_st.active = 1'b0;
          next_st.fsm = S_RUN;
        end
      end
    endcase

    if (st.stall) begin
      next_st.dly = st.dly - 8'h01;
      next_st.stall = st.dly != 8'h01;
    end

    if (is_hw && cmd.opcode != BDC_OP_ENTER && !st.mem.req) begin
      next_st.mem.req = 1'b1;
      next_st.mem.write = is_wr;
      next_st.mem.addr = cmd.addr;
      next_st.mem.data = cmd.data;
      next_st.mem.paged = page_q[BDC_PAGE_EN_BIT];
      next_st.mem.page = page_q[3:0];
      next_st.mem.debug_space = is_bd;
      if (is_bd && (cmd.addr <= BDC_FAMILY_ADDR) && bdc_in_space(cmd.addr)) begin
        next_st.mem.req = 1'b0;
        if (is_wr) begin
          if (cmd.addr == BDC_STATUS_ADDR) begin
            next_st.enable = cmd.data[BDC_ENABLE_BIT];
            next_st.active = cmd.data[BDC_ACTIVE_BIT] & st.active;
          end
          if (open_access && cmd.addr == BDC_HOLD_ADDR) begin
            hold_ld = 1'b1;
          end
          page_ld = open_access && cmd.addr == BDC_PAGE_ADDR;
        end else begin
          next_st.rvalid = 1'b1;
          unique case (cmd.addr)
            BDC_STATUS_ADDR: next_st.rdata = status;
            BDC_HOLD_ADDR:   next_st.rdata = open_access ? hold_q : 8'h00;
            BDC_PAGE_ADDR:   next_st.rdata = open_access ? page_q : 8'h00;
            BDC_FAMILY_ADDR: next_st.rdata = FAMILY_IDENTIFIER;
            default:         next_st.rdata = 8'h00;
          endcase
        end
      end
    end else if (steal_go) begin
      next_st.mem.req = 1'b0;
    end

    next_st.hidden = user_rd && user_addr >= BDC_SPACE_BASE && user_addr <= BDC_REG_LAST;
    // Registered so the overlay select has no decode glitch at the pin
    next_st.secmap = (next_st.fsm == S_SECCHK) || (next_st.fsm == S_LOOP);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st <= '{fsm: S_RESET, default: '0};
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    status = 8'h00;
    status[BDC_ENABLE_BIT] = st.enable;
    status[BDC_ACTIVE_BIT] = st.active;
    status[BDC_UNSECURED_FLAG_BIT] = st.unsecured_flag;
  end

  assign mem = st.mem;
  assign cpu_freeze = steal_freeze;
  assign cpu_stall = st.stall;
  assign fw_go = st.fw_go;
  assign fw_map = st.active;
  assign secure_map = st.secmap;
  assign restore_ccr = hold_q;
  assign saved_pc = st.pc;
  assign rd_data = st.rdata;
  assign rd_valid = st.rvalid;
  assign user_hidden = st.hidden;

  sequence SEQ_PEND;
    st.fsm == S_PEND && insn_end;
  endsequence

  // Halt while entry is not allowed and no delay is running starts a fresh delay
  sequence SEQ_DIS_HALT;
    st.fsm == S_RUN && !(st.enable && open_access) && halt_insn && !st.stall;
  endsequence

  // After-type breakpoint armed with no other trigger in the same cycle
  sequence SEQ_BRK_ARM;
    st.fsm == S_RUN && st.enable && open_access && brk_after && !halt_insn && !brk_before
      && !(is_hw && cmd.opcode == BDC_OP_ENTER) && !insn_end;
  endsequence

  AST_ENTRY_CCR: assert property (@(posedge clock) disable iff (rst)
    SEQ_PEND |=> restore_ccr == $past(cpu_ccr)) else $error("ccr not saved");
  AST_ENTRY_ACT: assert property (@(posedge clock) disable iff (rst)
    SEQ_PEND |=> status[BDC_ACTIVE_BIT] && fw_map) else $error("not active");
  AST_FW_GATE: assert property (@(posedge clock) disable iff (rst)
    fw_go |-> $past(st.fsm) == S_ACTIVE) else $error("fw ran inactive");
  AST_FW_DROP: assert property (@(posedge clock) disable iff (rst)
    cmd.valid && fw_cmd && st.fsm != S_ACTIVE |=> !fw_go) else $error("fw cmd not dropped");
  AST_DISABLED_ENTER: assert property (@(posedge clock) disable iff (rst)
    st.fsm == S_RUN && !st.enable && is_hw && cmd.opcode == BDC_OP_ENTER
      |=> st.fsm == S_RUN && !cpu_stall) else $error("enter not ignored");
  AST_STALL_START: assert property (@(posedge clock) disable iff (rst)
    SEQ_DIS_HALT |=> cpu_stall && st.dly == 8'(DELAY)) else $error("stall not started");
  AST_STALL_END: assert property (@(posedge clock) disable iff (rst)
    cpu_stall && st.dly == 8'h01 |=> !cpu_stall) else $error("stall too long");
  AST_FAIL_LOOP: assert property (@(posedge clock) disable iff (rst)
    st.fsm == S_SECCHK && erase_done && !erase_ok
      |=> status[BDC_ENABLE_BIT] && !status[BDC_UNSECURED_FLAG_BIT]) else $error("bad fail");
  AST_PASS: assert property (@(posedge clock) disable iff (rst)
    st.fsm == S_SECCHK && erase_done && erase_ok
      |=> status[BDC_UNSECURED_FLAG_BIT] && !secure_map) else $error("bad pass");
  AST_SSC_ENTRY: assert property (@(posedge clock) disable iff (rst)
    st.fsm == S_RESET && ssc_mode && !secured
      |=> status[BDC_ENABLE_BIT] && status[BDC_ACTIVE_BIT]) else $error("ssc not active");
  AST_ENTER_WAIT: assert property (@(posedge clock) disable iff (rst)
    st.fsm == S_PEND && !insn_end |=> !fw_map) else $error("entered mid instruction");
  AST_BRK_WAIT: assert property (@(posedge clock) disable iff (rst)
    SEQ_BRK_ARM |=> st.fsm == S_RUN && !fw_map) else $error("breakpoint entered early");
  AST_BRK_FIRE: assert property (@(posedge clock) disable iff (rst)
    SEQ_BRK_ARM ##1 insn_end |=> st.fsm == S_PEND) else $error("breakpoint not taken");
  // Overlap test compares the low 16 bits only; the window sits at the top page
  AST_PC_BUMP: assert property (@(posedge clock) disable iff (rst)
    st.fsm == S_PEND && insn_end && cpu_pc >= BDC_SPACE_BASE[15:0]
      |=> saved_pc == $past(cpu_pc) + 16'h0001) else $error("pc not bumped");
  AST_PC_KEEP: assert property (@(posedge clock) disable iff (rst)
    st.fsm == S_PEND && insn_end && cpu_pc < BDC_SPACE_BASE[15:0]
      |=> saved_pc == $past(cpu_pc)) else $error("pc changed");
  AST_HIDE: assert property (@(posedge clock) disable iff (rst)
    user_rd && user_addr == BDC_HOLD_ADDR |=> user_hidden) else $error("user saw reg");
  AST_FAMILY: assert property (@(posedge clock) disable iff (rst)
    is_hw && is_bd && !is_wr && cmd.addr == BDC_FAMILY_ADDR && !st.mem.req
      |=> rd_valid && rd_data == FAMILY_IDENTIFIER) else $error("id wrong");
  AST_LOCKED_READ: assert property (@(posedge clock) disable iff (rst)
    is_hw && is_bd && !is_wr && cmd.addr == BDC_HOLD_ADDR && !st.mem.req && !open_access
      |=> rd_valid && rd_data == 8'h00) else $error("locked reg leaked");
  // A reset or erase-check load of the enable in the same cycle loses to the host write
  AST_ENABLE_WR: assert property (@(posedge clock) disable iff (rst)
    is_hw && is_bd && is_wr && cmd.addr == BDC_STATUS_ADDR && !st.mem.req
      && st.fsm != S_SECCHK
      |=> status[BDC_ENABLE_BIT] == $past(cmd.data[BDC_ENABLE_BIT])) else $error("enable wr");
  AST_HW_LOCKED: assert property (@(posedge clock) disable iff (rst)
    cmd.valid && !fw_cmd && !dbg_allowed && !st.mem.req
      |=> !mem.req && !rd_valid) else $error("secured hw cmd ran");
  AST_BD_LOCAL: assert property (@(posedge clock) disable iff (rst)
    is_hw && is_bd && bdc_in_space(cmd.addr) && cmd.addr <= BDC_FAMILY_ADDR && !st.mem.req
      |=> !mem.req) else $error("debug reg went global");
  AST_MEM_PAGE: assert property (@(posedge clock) disable iff (rst)
    is_hw && !is_bd && cmd.opcode != BDC_OP_ENTER && !st.mem.req
      |=> mem.req && mem.paged == $past(page_q[BDC_PAGE_EN_BIT])) else $error("page enable");
  AST_MEM_SEL: assert property (@(posedge clock) disable iff (rst)
    is_hw && !is_bd && cmd.opcode != BDC_OP_ENTER && !st.mem.req
      |=> mem.page == $past(page_q[3:0])) else $error("page select");
  // A waiting access may only leave when a cycle is actually taken
  AST_MEM_HOLD: assert property (@(posedge clock) disable iff (rst)
    mem.req && !steal_go |=> mem.req) else $error("access dropped");
endmodule

// ### bench/bdc_host.sv
`timescale 1ns/1ps
module bdc_host
  import bdc_pkg::*;
(
  input  wire logic clock,  // Bus clock
  output bdc_cmd_t  cmd,    // Decoded command to the block
  output logic      fw_cmd  // Firmware class flag
);
  initial begin
    cmd    = '0;
    fw_cmd = 1'b0;
  end

  // one whole command per frame, hw or fw class
  task automatic send(input logic [7:0] op, input logic [17:0] a, input logic [7:0] d,
                      input logic fw);
    @(posedge clock);
    cmd    <= '{valid: 1'b1, opcode: op, addr: a, data: d};
    fw_cmd <= fw;
    @(posedge clock);
    // Released fields turn over so stale values never look fresh
    cmd    <= '{valid: 1'b0, opcode: ~op, addr: ~a, data: ~d};
    fw_cmd <= ~fw;
  endtask
endmodule

// ### bench/tb_bdc_core.sv
`timescale 1ns/1ps
module tb_bdc_core;
  import bdc_pkg::*;
  localparam logic [7:0] FAM = 8'h3C; // Arbitrary neutral family value
  logic        clock      = 1'b0;
  logic        rst        = 1'b1;
  logic        ssc_mode   = 1'b1;
  logic        secured    = 1'b0;
  logic        erase_done = 1'b0;
  logic        erase_ok   = 1'b0;
  logic        bus_free   = 1'b1;
  logic [5:0]  pls        = '0;
  logic [7:0]  cpu_ccr    = '0;
  logic [15:0] cpu_pc     = '0;
  logic [17:0] user_addr  = '0;
  bdc_cmd_t    cmd;
  bdc_mem_t    mem;
  logic        fw_cmd, cpu_freeze, cpu_stall, fw_go, fw_map, secure_map, rd_valid, user_hidden;
  logic [7:0]  restore_ccr, rd_data, status;
  logic [15:0] saved_pc;
  int          fails      = 0;
  int          compares   = 0;

  always #4 clock = ~clock;

  bdc_host host (.clock(clock), .cmd(cmd), .fw_cmd(fw_cmd));

  bdc_core #(.FAMILY_IDENTIFIER(FAM), .DELAY(BDC_DELAY_CYC)) dut (
    .clock(clock), .rst(rst), .ssc_mode(ssc_mode), .secured(secured),
    .erase_done(erase_done), .erase_ok(erase_ok), .cmd(cmd), .fw_cmd(fw_cmd),
    .halt_insn(pls[0]), .brk_before(pls[1]), .brk_after(pls[2]), .insn_end(pls[3]),
    .cpu_ccr(cpu_ccr), .cpu_pc(cpu_pc), .fw_exit(pls[4]), .bus_free(bus_free),
    .user_rd(pls[5]), .user_addr(user_addr), .mem(mem), .cpu_freeze(cpu_freeze),
    .cpu_stall(cpu_stall), .fw_go(fw_go), .fw_map(fw_map), .secure_map(secure_map),
    .restore_ccr(restore_ccr), .saved_pc(saved_pc), .rd_data(rd_data),
    .rd_valid(rd_valid), .user_hidden(user_hidden), .status(status));

  task automatic print_verdict();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_bit(input string name, input logic exp, input logic got);
    check(name, {15'h0, exp}, {15'h0, got});
  endtask

  function automatic logic probe(input int s);
    case (s)
      0: return fw_go;
      1: return user_hidden;
      2: return status[BDC_ACTIVE_BIT];
      3: return cpu_stall;
      default: return status[BDC_ENABLE_BIT];
    endcase
  endfunction

  // Called in the time step of an edge, so a one-cycle pulse launched there is seen
  task automatic watch(input string name, input int s, input int lim, input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (lim) begin
      #1;
      seen = seen | (probe(s) === 1'b1);
      @(posedge clock);
    end
    #1;
    check_bit(name, exp, seen);
  endtask

  task automatic pulse(input int b);
    @(posedge clock);
    pls[b] <= 1'b1;
    @(posedge clock);
    pls[b] <= 1'b0;
  endtask

  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    host.send(BDC_OP_WR_BD, a, d, 1'b0);
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic rd(input string name, input logic [17:0] a, input logic [7:0] exp);
    int n;
    host.send(BDC_OP_RD_BD, a, 8'h00, 1'b0);
    n = 0;
    #1;
    while (rd_valid !== 1'b1) begin
      n++;
      if (n > 4) begin
        check(name, 16'h0001, 16'h0000);
        print_verdict();
      end
      @(posedge clock);
      #1;
    end
    check(name, {8'h0, exp}, {8'h0, rd_data});
  endtask

  task automatic do_reset(input logic ssc, input logic sec, input logic eok);
    @(posedge clock);
    rst        <= 1'b1;
    ssc_mode   <= ssc;
    secured    <= sec;
    erase_ok   <= eok;
    erase_done <= 1'b0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
  endtask

  initial begin
    int cnt;
    do_reset(1'b1, 1'b0, 1'b0);
    check("status_ssc", 16'h00C0, {8'h0, status & 8'hC0});
    rd("hold_rst", BDC_HOLD_ADDR, BDC_HOLD_RST_SSC);
    rd("family", BDC_FAMILY_ADDR, FAM);
    wr(BDC_HOLD_ADDR, 8'hA5);
    rd("hold_wr", BDC_HOLD_ADDR, 8'hA5);
    check("restore", 16'h00A5, {8'h0, restore_ccr});
    wr(BDC_PAGE_ADDR, 8'h83);
    rd("page", BDC_PAGE_ADDR, 8'h83);
    // Paged read with no free cycle, so the access has to steal one
    @(posedge clock);
    bus_free <= 1'b0;
    host.send(BDC_OP_RD_BYTE, 18'h08123, 8'h00, 1'b0);
    #1;
    cnt = 0;
    while (cpu_freeze !== 1'b1) begin
      cnt++;
      if (cnt > 200) begin
        check("freeze_wait", 16'h0001, 16'h0000);
        print_verdict();
      end
      @(posedge clock);
      #1;
      if (cnt == 3) begin
        check("mem_paged", 16'h0093, {8'h0, mem.req, mem.write, mem.debug_space, mem.paged,
                                      mem.page});
        check("mem_addr", 16'h8123, mem.addr[15:0]);
      end
    end
    check_bit("steal_cnt", 1'b1, cnt >= BDC_STEAL_CYCLES - 4 && cnt <= BDC_STEAL_CYCLES + 8);
    @(posedge clock);
    bus_free <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    check_bit("mem_done", 1'b0, mem.req);
    host.send(BDC_OP_WR_PC, 18'h0, 8'h12, 1'b1);
    watch("fw_go_act", 0, 3, 1'b1);
    check("pc_write", 16'h0012, saved_pc);
    pulse(4);
    repeat (2) @(posedge clock);
    #1;
    check_bit("exit", 1'b0, status[BDC_ACTIVE_BIT]);
    check_bit("unmap", 1'b0, fw_map);
    host.send(BDC_OP_WR_PC, 18'h0, 8'h12, 1'b1);
    watch("fw_go_idle", 0, 3, 1'b0);
    // Entry by halt, both breakpoint kinds and the enter command
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      cpu_ccr <= 8'h40 + 8'(i);
      cpu_pc  <= (i == 0) ? 16'hFF10 : 16'h1230 + 16'(i);
      if (i == 3)
        host.send(BDC_OP_ENTER, 18'h0, 8'h00, 1'b0);
      else
        pulse(i);
      repeat (2) @(posedge clock);
      #1;
      if (i == 0 || i == 3)
        check_bit("pre_end", 1'b0, status[BDC_ACTIVE_BIT]);
      pulse(3);
      pulse(3);
      #1;
      check_bit("entered", 1'b1, status[BDC_ACTIVE_BIT]);
      check_bit("mapped", 1'b1, fw_map);
      rd("hold_entry", BDC_HOLD_ADDR, 8'h40 + 8'(i));
      check("saved_pc", (i == 0) ? 16'hFF11 : 16'h1230 + 16'(i), saved_pc);
      pulse(4);
      repeat (2) @(posedge clock);
    end
    @(posedge clock);
    user_addr <= BDC_HOLD_ADDR;
    pulse(5);
    watch("user_hidden", 1, 3, 1'b1);
    wr(BDC_STATUS_ADDR, 8'h00);
    check_bit("disabled", 1'b0, status[BDC_ENABLE_BIT]);
    host.send(BDC_OP_ENTER, 18'h0, 8'h00, 1'b0);
    watch("enter_nostall", 3, 12, 1'b0);
    check_bit("enter_ignored", 1'b0, status[BDC_ACTIVE_BIT]);
    pulse(0);
    cnt = 0;
    repeat (40) begin
      #1;
      if (cpu_stall === 1'b1)
        cnt++;
      @(posedge clock);
    end
    check("stall_len", 16'(BDC_DELAY_CYC), 16'(cnt));
    wr(BDC_STATUS_ADDR, 8'h80);
    check_bit("enabled", 1'b1, status[BDC_ENABLE_BIT]);
    // Secure reset with a failed and then a passed erase check
    for (int k = 0; k < 2; k++) begin
      do_reset(1'b1, 1'b1, k == 1);
      check_bit("sec_map", 1'b1, secure_map);
      @(posedge clock);
      erase_done <= 1'b1;
      watch("sec_enable", 4, 20, 1'b1);
      check_bit("sec_unsecured_flag", k == 1, status[BDC_UNSECURED_FLAG_BIT]);
      check_bit("sec_map_off", k == 0, secure_map);
      rd("sec_hold", BDC_HOLD_ADDR, (k == 1) ? BDC_HOLD_RST_SSC : 8'h00);
    end
    do_reset(1'b0, 1'b1, 1'b0);
    wr(BDC_STATUS_ADDR, 8'h80);
    check_bit("sec_refused", 1'b0, status[BDC_ENABLE_BIT]);
    do_reset(1'b0, 1'b0, 1'b0);
    rd("hold_oth", BDC_HOLD_ADDR, BDC_HOLD_RST_OTH);
    print_verdict();
  end
endmodule
